// >>> hdl/pmscc_regs.svh
/*
 * register offsets, field positions and reset values of the power-manager
 * status group. assumes byte-wide registers behind an indexed port.
 */
`ifndef PMSCC_REGS_SVH
`define PMSCC_REGS_SVH

// ==========================================================================
// offsets
`define PMSCC_OFS_PROC_STATUS   8'ha4
`define PMSCC_OFS_EVENT_SOURCE  8'ha5
`define PMSCC_OFS_CARD_FLAGS    8'ha6
`define PMSCC_OFS_PM_CONTROL    8'ha7

// ==========================================================================
// field positions
`define PMSCC_BIT_GP_PIN_ONE    3
`define PMSCC_BIT_AC_ADAPTER    7
`define PMSCC_BIT_EVT_RESUME    0
`define PMSCC_BIT_EVT_LOW_DOZE  1
`define PMSCC_BIT_EVT_DOZE_SLP  2
`define PMSCC_BIT_EVT_SLP_SUSP  3
`define PMSCC_BIT_EVT_SUSP_OFF  4
`define PMSCC_BIT_EVT_BATT1     5
`define PMSCC_BIT_EVT_BATT2     6
`define PMSCC_BIT_EVT_BATT3     7
`define PMSCC_BIT_BLOCK_DISP    4
`define PMSCC_BIT_BLOCK_SER     5
`define PMSCC_BIT_SLOW_REF_DIS  1
`define PMSCC_BIT_REF_SOURCE    0

// ==========================================================================
// masks and reset values
`define PMSCC_CTRL_WMASK        8'h33
`define PMSCC_RESET_BYTE        8'h00

// ==========================================================================
// timing counts
// cycles after reset before the edge stage holds a real pin level
`define PMSCC_SYNC_FILL         2'h3

`endif

// >>> hdl/pmscc_pkg.sv
/*
 * types of the power-manager status group.
 * assumes pmscc_regs.svh holds every register number; the mode codes stand here.
 */
`default_nettype none

package pmscc_pkg;

  // ========================================================================
  // present power-mode codes
  typedef enum logic [2:0] {
    PMSCC_MODE_FULL    = 3'h0,
    PMSCC_MODE_LOW     = 3'h4,
    PMSCC_MODE_DOZE    = 3'h1,
    PMSCC_MODE_SLEEP   = 3'h3,
    PMSCC_MODE_SUSPEND = 3'h2
  } pmscc_mode_t;

  // ========================================================================
  // transition hold machine
  typedef enum logic [2:0] {
    PMSCC_ST_RUN  = 3'b001,
    PMSCC_ST_HOLD = 3'b010,
    PMSCC_ST_GO   = 3'b100
  } pmscc_state_t;

endpackage : pmscc_pkg

`default_nettype wire

// >>> hdl/pmscc_top.sv
/*
 * power-manager status, event-source, card pin-change and control registers.
 * assumes: pins are asynchronous and are synchronised here; the mode
 * sequencer, idle timer and refresh generator live outside this block.
 */
//
// Summary of operation
// - previous-mode field kept valid from wake to full speed until idle timeout.
// - present power mode readable in bits 2..0 with the listed encodings.
// - gp pin one level at bit 3, ac adapter level at bit 7.
// - event-source read returns the cause of the latest nmi or smi.
// - interrupting transition is held until refresh after event-source write.
// - event bits 4..1 mark suspend-off, sleep-suspend, doze-sleep, low-doze.
// - event bits 7,6,5 mark battery warnings three, two, one.
// - event bit 0 marks the suspend/wake pin as cause.
// - a flag clears only on a 0 write followed by a 1 write.
// - memory card, falling battery-two pin sets bit 7 (b) or 6 (a).
// - falling battery-one (memory) or status-change (io) sets bit 5/4.
// - memory card, rising ready pin sets bit 3 (b) or 2 (a).
// - any card-detect change sets bit 1 (b) or bit 0 (a).
// - control bit 5 blocks serial and power-manager data in memory cycles.
// - control bit 4 blocks display data in memory cycles.
// - refresh source bit 0: 0 doubled 32 khz, 1 interval timer; overrides.
// - with bit 0 clear, slow refresh bit 1 at 0 enables slow refresh.
// - slow refresh setting survives leaving micro power-off.
`timescale 1ns/10ps
`default_nettype none
`include "pmscc_regs.svh"

module pmscc_top
  import pmscc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // power sequencer side
  input  wire logic [2:0] seq_mode,
  input  wire logic [2:0] seq_prev_mode,
  input  wire logic       seq_wake_to_full,
  input  wire logic       seq_idle_expired,
  input  wire logic [7:0] seq_event,
  input  wire logic       seq_trans_pending,
  input  wire logic       refresh_cycle,
  input  wire logic       micro_off_exit,
  output logic            trans_release,
  output logic      [2:0] prev_mode,
  output logic            prev_mode_valid,
  // pins
  input  wire logic       ac_adapter_level,
  input  wire logic       gp_pin_one,
  input  wire logic       sock_a_is_io,
  input  wire logic       sock_b_is_io,
  input  wire logic       sock_a_batt_volt_one,
  input  wire logic       sock_a_batt_volt_two,
  input  wire logic       sock_b_batt_volt_one,
  input  wire logic       sock_b_batt_volt_two,
  input  wire logic       sock_a_status_change_pin,
  input  wire logic       sock_b_status_change_pin,
  input  wire logic       sock_a_ready,
  input  wire logic       sock_b_ready,
  input  wire logic       sock_a_card_detect_n,
  input  wire logic       sock_b_card_detect_n,
  // control outputs and the memory-cycle input that gates the two block outputs
  input  wire logic       mem_cycle,
  output logic            block_serial_pm_data,
  output logic            block_display_data,
  output logic            slow_refresh_on,
  output logic            refresh_source_select
);

  // ========================================================================
  // pin synchronisers: stage one is read only by stage two
  localparam int NPIN = 14;
  // positions of each pin in the sync vector
  localparam int PIN_AC    = 13;
  localparam int PIN_GP    = 12;
  localparam int PIN_A_IO  = 11;
  localparam int PIN_B_IO  = 10;
  localparam int PIN_A_BV1 = 9;
  localparam int PIN_A_BV2 = 8;
  localparam int PIN_B_BV1 = 7;
  localparam int PIN_B_BV2 = 6;
  localparam int PIN_A_STS = 5;
  localparam int PIN_B_STS = 4;
  localparam int PIN_A_RDY = 3;
  localparam int PIN_B_RDY = 2;
  localparam int PIN_A_CD  = 1;
  localparam int PIN_B_CD  = 0;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_d;

  assign pin_raw = {ac_adapter_level, gp_pin_one, sock_a_is_io,
                    sock_b_is_io, sock_a_batt_volt_one,
                    sock_a_batt_volt_two, sock_b_batt_volt_one,
                    sock_b_batt_volt_two, sock_a_status_change_pin,
                    sock_b_status_change_pin, sock_a_ready,
                    sock_b_ready, sock_a_card_detect_n,
                    sock_b_card_detect_n};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d  <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  logic ac_s;
  logic gp_s;
  logic a_io;
  logic b_io;
  assign ac_s = pin_s2[PIN_AC];
  assign gp_s = pin_s2[PIN_GP];
  assign a_io = pin_s2[PIN_A_IO];
  assign b_io = pin_s2[PIN_B_IO];

  function automatic logic fall(input logic cur, input logic old);
    fall = old & ~cur;
  endfunction : fall

  function automatic logic rise(input logic cur, input logic old);
    rise = cur & ~old;
  endfunction : rise

  function automatic logic toggled(input logic cur, input logic old);
    toggled = cur ^ old;
  endfunction : toggled

  // ========================================================================
  // edge detection waits until the edge stage holds real pin levels;
  // otherwise a pin that idles high fakes an edge right after reset
  logic [1:0] sync_fill;
  logic       edges_live;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_fill <= 2'h0;
    end else if (sync_fill != `PMSCC_SYNC_FILL) begin
      sync_fill <= sync_fill + 2'h1;
    end
  end
  assign edges_live = (sync_fill == `PMSCC_SYNC_FILL);

  // ========================================================================
  // register decode
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  logic wr_event;
  logic wr_flags;
  logic wr_ctrl;
  assign wr_event = reg_wr && addr_hit(reg_addr, `PMSCC_OFS_EVENT_SOURCE);
  assign wr_flags = reg_wr && addr_hit(reg_addr, `PMSCC_OFS_CARD_FLAGS);
  assign wr_ctrl  = reg_wr && addr_hit(reg_addr, `PMSCC_OFS_PM_CONTROL);

  // ========================================================================
  // present mode and previous mode
  logic [2:0] mode_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
    end else begin
      mode_q <= seq_mode;
    end
  end

  // window opens on wake to full speed and closes at idle timeout
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_mode       <= 3'h0;
      prev_mode_valid <= 1'b0;
    end else if (seq_wake_to_full) begin
      prev_mode       <= seq_prev_mode;
      prev_mode_valid <= 1'b1;
    end else if (seq_idle_expired) begin
      prev_mode_valid <= 1'b0;
    end
  end

  // ========================================================================
  // event source: hardware sets win over a software write
  logic [7:0] event_src;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_src <= `PMSCC_RESET_BYTE;
    end else if (wr_event) begin
      event_src <= reg_wdata | seq_event;
    end else begin
      event_src <= event_src | seq_event;
    end
  end

  // ========================================================================
  // transition hold: release on the refresh cycle after the write
  pmscc_state_t state;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= PMSCC_ST_RUN;
      trans_release <= 1'b0;
    end else begin
      trans_release <= 1'b0;
      unique case (state)
        PMSCC_ST_RUN: begin
          if (seq_trans_pending) begin
            state <= PMSCC_ST_HOLD;
          end
        end
        PMSCC_ST_HOLD: begin
          if (wr_event) begin
            state <= PMSCC_ST_GO;
          end
        end
        PMSCC_ST_GO: begin
          if (refresh_cycle) begin
            trans_release <= 1'b1;
            state         <= PMSCC_ST_RUN;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // card pin-change flags
  logic [7:0] flag_set;
  always_comb begin
    flag_set = 8'h00;
    if (edges_live) begin
      flag_set[7] = ~b_io & fall(pin_s2[PIN_B_BV2], pin_d[PIN_B_BV2]);
      flag_set[6] = ~a_io & fall(pin_s2[PIN_A_BV2], pin_d[PIN_A_BV2]);
      flag_set[5] = b_io ? fall(pin_s2[PIN_B_STS], pin_d[PIN_B_STS])
                         : fall(pin_s2[PIN_B_BV1], pin_d[PIN_B_BV1]);
      flag_set[4] = a_io ? fall(pin_s2[PIN_A_STS], pin_d[PIN_A_STS])
                         : fall(pin_s2[PIN_A_BV1], pin_d[PIN_A_BV1]);
      flag_set[3] = ~b_io & rise(pin_s2[PIN_B_RDY], pin_d[PIN_B_RDY]);
      flag_set[2] = ~a_io & rise(pin_s2[PIN_A_RDY], pin_d[PIN_A_RDY]);
      flag_set[1] = toggled(pin_s2[PIN_B_CD], pin_d[PIN_B_CD]);
      flag_set[0] = toggled(pin_s2[PIN_A_CD], pin_d[PIN_A_CD]);
    end
  end

  // armed bits remember a 0 write; a later 1 write clears the flag
  logic [7:0] flags;
  logic [7:0] armed;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed <= 8'h00;
    end else if (wr_flags) begin
      armed <= ~reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= `PMSCC_RESET_BYTE;
    end else if (wr_flags) begin
      // set wins over the clear in the same cycle
      flags <= (flags & ~(armed & reg_wdata)) | flag_set;
    end else begin
      flags <= flags | flag_set;
    end
  end

  // ========================================================================
  // control register; slow refresh bit not touched by micro power-off exit
  logic [7:0] ctrl;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= `PMSCC_RESET_BYTE;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata & `PMSCC_CTRL_WMASK;
    end else if (micro_off_exit) begin
      // other control bits return to default, slow refresh is kept
      ctrl <= ctrl & (8'h01 << `PMSCC_BIT_SLOW_REF_DIS);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_serial_pm_data  <= 1'b0;
      block_display_data    <= 1'b0;
      slow_refresh_on       <= 1'b0;
      refresh_source_select <= 1'b0;
    end else begin
      block_serial_pm_data  <= mem_cycle & ctrl[`PMSCC_BIT_BLOCK_SER];
      block_display_data    <= mem_cycle & ctrl[`PMSCC_BIT_BLOCK_DISP];
      // timer source overrides slow refresh
      slow_refresh_on       <= ~ctrl[`PMSCC_BIT_REF_SOURCE]
                               & ~ctrl[`PMSCC_BIT_SLOW_REF_DIS];
      refresh_source_select <= ctrl[`PMSCC_BIT_REF_SOURCE];
    end
  end

  // ========================================================================
  // read port, data one cycle after the strobe
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[2:0] = mode_q;
    status_byte[`PMSCC_BIT_GP_PIN_ONE] = gp_s;
    status_byte[`PMSCC_BIT_AC_ADAPTER] = ac_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PMSCC_OFS_PROC_STATUS:  reg_rdata <= status_byte;
        `PMSCC_OFS_EVENT_SOURCE: reg_rdata <= event_src;
        `PMSCC_OFS_CARD_FLAGS:   reg_rdata <= flags;
        `PMSCC_OFS_PM_CONTROL:   reg_rdata <= ctrl;
        default:                 reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : pmscc_top

`default_nettype wire

// >>> tb/pmscc_props.sv
/*
 * assertions on the ports of the power-manager status group.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module pmscc_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       refresh_cycle,
  input wire logic       trans_release,
  input wire logic       mem_cycle,
  input wire logic       block_serial_pm_data,
  input wire logic       block_display_data,
  input wire logic       slow_refresh_on,
  input wire logic       refresh_source_select,
  input wire logic       seq_wake_to_full,
  input wire logic       seq_idle_expired,
  input wire logic       prev_mode_valid
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_unmapped;
    reg_rd && (reg_addr < 8'ha4 || reg_addr > 8'ha7);
  endsequence
  sequence s_rd_ctrl;
    reg_rd && reg_addr == 8'ha7;
  endsequence
  sequence s_rd_status;
    reg_rd && reg_addr == 8'ha4;
  endsequence

  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_unmap; s_rd_unmapped |=> reg_rdata == 8'h00; endproperty
  property p_rsv_ctrl; s_rd_ctrl |=> (reg_rdata & 8'hcc) == 8'h00; endproperty
  property p_rel_cause; trans_release |-> $past(refresh_cycle); endproperty
  property p_rel_pulse; trans_release |=> !trans_release; endproperty
  property p_rsv_stat;
    s_rd_status |=> (reg_rdata & 8'h70) == 8'h00;
  endproperty
  property p_blk_ser; block_serial_pm_data |-> $past(mem_cycle); endproperty
  property p_blk_dsp; block_display_data |-> $past(mem_cycle); endproperty
  property p_ref_ovr; refresh_source_select |-> !slow_refresh_on; endproperty
  property p_prev_clr;
    seq_idle_expired && !seq_wake_to_full |=> !prev_mode_valid;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("stray rdata");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read");
  a_rsv_ctrl: assert property (p_rsv_ctrl)
    else $error("ctrl rsv");
  a_rsv_stat: assert property (p_rsv_stat)
    else $error("status rsv");
  a_rel_cause: assert property (p_rel_cause)
    else $error("release");
  a_rel_pulse: assert property (p_rel_pulse)
    else $error("long rel");
  a_blk_ser: assert property (p_blk_ser)
    else $error("serial block");
  a_blk_dsp: assert property (p_blk_dsp)
    else $error("display block");
  a_ref_ovr: assert property (p_ref_ovr)
    else $error("ref override");
  a_prev_clr: assert property (p_prev_clr)
    else $error("prev valid");
endmodule : pmscc_props

bind pmscc_top pmscc_props u_props (
  .clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .refresh_cycle,
  .trans_release, .mem_cycle, .block_serial_pm_data, .block_display_data,
  .slow_refresh_on,
  .refresh_source_select, .seq_wake_to_full, .seq_idle_expired,
  .prev_mode_valid
);

`default_nettype wire

// >>> tb/pmscc_sock.sv
/*
 * card socket pin model: the ten status pins of both sockets.
 * assumes the bench calls flip; pin order matches the change-flag bits.
 */
`timescale 1ns/10ps
`default_nettype none

module pmscc_sock (
  input  wire logic       clk,
  output var  logic [9:0] pin
);
  // ==========================================================================
  // battery and status-change idle high, ready low; socket b is empty,
  // so its detect pin idles high and must not flag a change at reset
  initial pin = 10'h3f2;

  // changes land just after an edge so the sync flops see clean levels
  task automatic flip(input int i);
    @(posedge clk);
    pin[i] <= ~pin[i];
  endtask : flip
endmodule : pmscc_sock

`default_nettype wire

// >>> tb/tb_top.sv
/*
 * self-checking bench of the power-manager status group.
 * assumes pins take three cycles through the sync flops.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import pmscc_pkg::*;
  logic       clk, rst_n, reg_wr, reg_rd, refresh_cycle, micro_off_exit;
  logic       seq_wake_to_full, seq_idle_expired, seq_trans_pending;
  logic       ac_adapter_level, gp_pin_one, sock_a_is_io, sock_b_is_io;
  logic       mem_cycle, trans_release, prev_mode_valid, slow_refresh_on;
  logic       block_serial_pm_data, block_display_data, refresh_source_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, seq_event;
  logic [2:0] seq_mode, seq_prev_mode, prev_mode;
  logic [9:0] pin;
  int         failures, n_compared, cycles;

  // ==========================================================================
  // design and socket model
  pmscc_sock u_sock (.clk, .pin);
  pmscc_top u_dut (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .seq_mode, .seq_prev_mode, .seq_wake_to_full, .seq_idle_expired,
    .seq_event, .seq_trans_pending, .refresh_cycle, .micro_off_exit,
    .trans_release, .prev_mode, .prev_mode_valid, .ac_adapter_level,
    .gp_pin_one, .sock_a_is_io, .sock_b_is_io, .mem_cycle,
    .sock_a_card_detect_n(pin[0]), .sock_b_card_detect_n(pin[1]),
    .sock_a_ready(pin[2]), .sock_b_ready(pin[3]),
    .sock_a_batt_volt_one(pin[4]), .sock_b_batt_volt_one(pin[5]),
    .sock_a_batt_volt_two(pin[6]), .sock_b_batt_volt_two(pin[7]),
    .sock_a_status_change_pin(pin[8]), .sock_b_status_change_pin(pin[9]),
    .block_serial_pm_data, .block_display_data, .slow_refresh_on,
    .refresh_source_select
  );

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chk1

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rchk

  task automatic pulse_refresh;
    @(posedge clk);
    refresh_cycle <= 1'b1;
    @(posedge clk);
    refresh_cycle <= 1'b0;
    @(negedge clk);
  endtask : pulse_refresh

  // ==========================================================================
  // scenarios
  task automatic t_status;
    logic [2:0] m [5] = '{3'h0, 3'h4, 3'h1, 3'h3, 3'h2};
    wr(8'ha4, 8'hff);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      seq_mode         <= m[i];
      ac_adapter_level <= i[0];
      gp_pin_one       <= ~i[0];
      idle(4);
      rchk(8'ha4, {i[0], 3'h0, ~i[0], m[i]});
    end
  endtask : t_status

  task automatic t_event;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      seq_event <= 8'h01 << i;
      @(posedge clk);
      seq_event <= 8'h00;
      rchk(8'ha5, 8'h01 << i);
      wr(8'ha5, 8'h00);
    end
  endtask : t_event

  task automatic t_hold;
    @(posedge clk);
    seq_trans_pending <= 1'b1;
    @(posedge clk);
    seq_trans_pending <= 1'b0;
    pulse_refresh();
    chk1(trans_release, 1'b0);
    wr(8'ha5, 8'h00);
    pulse_refresh();
    chk1(trans_release, 1'b1);
  endtask : t_hold

  // io cards first: both edges of every pin but card detect, only status-change falls count
  task automatic t_flags;
    wr(8'ha6, 8'h00);
    wr(8'ha6, 8'hff);
    sock_a_is_io <= 1'b1;
    sock_b_is_io <= 1'b1;
    for (int i = 4; i < 20; i++) begin
      if (i == 16) rchk(8'ha6, 8'h00);
      u_sock.flip(i / 2);
      idle(4);
    end
    rchk(8'ha6, 8'h30);
    wr(8'ha6, 8'h00);
    wr(8'ha6, 8'hff);
    sock_a_is_io <= 1'b0;
    sock_b_is_io <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      u_sock.flip(i);
      idle(4);
      rchk(8'ha6, (8'h02 << i) - 8'h01);
    end
    wr(8'ha6, 8'hfe);
    wr(8'ha6, 8'hff);
    rchk(8'ha6, 8'hfe);
    wr(8'ha6, 8'h00);
    rchk(8'ha6, 8'hfe);
    wr(8'ha6, 8'hff);
    rchk(8'ha6, 8'h00);
  endtask : t_flags

  task automatic t_ctrl;
    logic [7:0] w [3] = '{8'hff, 8'h12, 8'h20};
    logic [3:0] e [3] = '{4'b1101, 4'b0100, 4'b1010};
    @(posedge clk);
    mem_cycle <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'ha7, w[i]);
      rchk(8'ha7, w[i] & 8'h33);
      chk({4'h0, block_serial_pm_data, block_display_data,
           slow_refresh_on, refresh_source_select},
          {4'h0, e[i]});
    end
    // outside memory cycles nothing is blocked
    wr(8'ha7, 8'h33);
    mem_cycle <= 1'b0;
    idle(2);
    @(negedge clk);
    chk({6'h0, block_serial_pm_data, block_display_data},
        8'h00);
    wr(8'ha7, 8'h23);
    @(posedge clk);
    micro_off_exit <= 1'b1;
    @(posedge clk);
    micro_off_exit <= 1'b0;
    rchk(8'ha7, 8'h02);
    wr(8'h10, 8'hff);
    rchk(8'h10, 8'h00);
  endtask : t_ctrl

  task automatic t_prev;
    @(posedge clk);
    seq_prev_mode    <= 3'h3;
    seq_wake_to_full <= 1'b1;
    @(posedge clk);
    seq_wake_to_full <= 1'b0;
    @(negedge clk);
    chk({4'h0, prev_mode_valid, prev_mode}, 8'h0b);
    @(posedge clk);
    seq_idle_expired <= 1'b1;
    @(posedge clk);
    seq_idle_expired <= 1'b0;
    @(negedge clk);
    chk1(prev_mode_valid, 1'b0);
  endtask : t_prev

  // ==========================================================================
  // run control
  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // a hang costs at most this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {reg_wr, reg_rd, refresh_cycle, micro_off_exit, seq_wake_to_full,
     seq_idle_expired, seq_trans_pending, ac_adapter_level, gp_pin_one,
     sock_a_is_io, sock_b_is_io, mem_cycle, rst_n} = '0;
    {reg_addr, reg_wdata, seq_event, seq_mode, seq_prev_mode} = '0;
    idle(16);
    rst_n <= 1'b1;
    idle(4);
    rchk(8'ha5, 8'h00);
    rchk(8'ha7, 8'h00);
    rchk(8'ha6, 8'h00);
    t_status();
    t_event();
    t_hold();
    t_flags();
    t_ctrl();
    t_prev();
    conclude();
  end
endmodule : tb_top

`default_nettype wire
